// ---- core/osc_clock_control.sv ----
// Oscillator start-up timers, slow clock synthesis/select and power-on reset
// Summary of operation
// - Main stop request holds 14-bit timer at 3FFFh, fast oscillator off.
// - Main stop released: restart fast oscillator, count timer down.
// - Main timer at zero stops and raises good main clock.
// - Good main clock follows 32,768 clock cycles after each restart.
// - Slow stop request holds 6-bit timer at 3Fh, slow oscillator off.
// - Slow stop released: restart slow oscillator, count timer down.
// - Slow timer at zero freezes and raises good slow clock.
// - Synthesised slow clock: 8-bit prescaler then divide-by-2, divisors 2 to 512.
// - Software selects slow clock source; prescaled main clock after reset.
// - Oscillator selected as source disables the main clock prescaler.
// - Switch to oscillator only while it is seen toggling.
// - Power-on counter from 3FFFh releases internal reset unless pin low.
//
// The AXI4-Lite interface to the registers and the address map were decided locally.

`timescale 1ns/1ps
`default_nettype none
`include "osc_ctrl_map.svh"

module osc_clock_control (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire osc_ctrl_pkg::axil_req_t axil_req,
  output osc_ctrl_pkg::axil_rsp_t axil_rsp,
  input wire logic stop_main_osc,
  input wire logic stop_slow_osc,
  input wire logic slow_osc_in,
  input wire logic ext_reset_n,
  output logic fast_oscillator_clock_en,
  output logic slow_osc_en,
  output logic good_main_clk,
  output logic good_slow_clk,
  output logic slow_clk,
  output logic sys_rst_n
);
  import osc_ctrl_pkg::*;

  // Control register fields
  logic sel_osc_req;
  logic [7:0] prescale;

  // Main oscillator start-up
  logic [13:0] main_tmr;
  logic main_tick;

  // Slow oscillator start-up and activity watch
  logic [5:0] slow_tmr;
  logic slow_prev;
  logic slow_rise;
  logic [12:0] idle_cnt;
  logic toggling;

  // Synthesised slow clock and source select
  logic pre_run;
  logic [7:0] pre_cnt;
  logic synth_clk;
  slow_src_t src;
  logic mux_level;

  // Power-on reset release
  logic [13:0] por_cnt;

  // Bus transfer strobes
  logic wr_go;
  logic rd_go;

  // Address decode shared by the write and read channels
  function automatic logic is_ctrl(input logic [3:0] a);
    is_ctrl = (a == `OFF_CTRL);
  endfunction

  function automatic logic is_status(input logic [3:0] a);
    is_status = (a == `OFF_STATUS);
  endfunction

  // Rising edge of the oscillator as seen on this clock
  assign slow_rise = slow_osc_in & ~slow_prev;
  // Clean because src only moves while both inputs are low
  assign mux_level = (src == SRC_OSC) ? slow_osc_in : synth_clk;
  // Transfer edges of the two bus channels
  assign wr_go = axil_req.awvalid & axil_req.wvalid & axil_rsp.awready & axil_rsp.wready;
  assign rd_go = axil_req.arvalid & axil_rsp.arready;

  // Main oscillator: one timer step every MAIN_TICK_CYC cycles gives the delay
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      main_tmr <= `MAIN_TMR_PRESET;
      main_tick <= 1'b0;
      fast_oscillator_clock_en <= 1'b0;
      good_main_clk <= 1'b0;
    end else if (stop_main_osc) begin
      // Stop wins over the count in the same cycle
      main_tmr <= `MAIN_TMR_PRESET;
      main_tick <= 1'b0;
      fast_oscillator_clock_en <= 1'b0;
      good_main_clk <= 1'b0;
    end else begin
      fast_oscillator_clock_en <= 1'b1;
      main_tick <= ~main_tick;
      // Half-rate steps: 16383 of them span the start-up delay
      if (main_tmr != 14'h0 && main_tick) begin
        main_tmr <= main_tmr - 14'h1;
      end
      // Registered, so the flag rises one edge after the timer empties
      good_main_clk <= (main_tmr == 14'h0);
    end
  end

  // Slow oscillator start-up timer counts oscillator rising edges
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slow_tmr <= `SLOW_TMR_PRESET;
      slow_prev <= 1'b0;
      slow_osc_en <= 1'b0;
      good_slow_clk <= 1'b0;
    end else if (stop_slow_osc) begin
      slow_tmr <= `SLOW_TMR_PRESET;
      // Cleared so a restart never sees a stale edge
      slow_prev <= 1'b0;
      slow_osc_en <= 1'b0;
      good_slow_clk <= 1'b0;
    end else begin
      slow_osc_en <= 1'b1;
      slow_prev <= slow_osc_in;
      // Counts crystal edges, so the delay follows the crystal
      if (slow_tmr != 6'h0 && slow_rise) begin
        slow_tmr <= slow_tmr - 6'h1;
      end
      good_slow_clk <= (slow_tmr == 6'h0);
    end
  end

  // Toggle detector: a silent oscillator for TOGGLE_TIMEOUT_CYC cycles is dead
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      idle_cnt <= `TOGGLE_TIMEOUT_CYC;
      toggling <= 1'b0;
    end else if (stop_slow_osc) begin
      idle_cnt <= `TOGGLE_TIMEOUT_CYC;
      toggling <= 1'b0;
    end else if (slow_rise) begin
      idle_cnt <= 13'h0;
      // Only a crystal past its start-up counts as toggling
      toggling <= good_slow_clk;
    end else if (idle_cnt != `TOGGLE_TIMEOUT_CYC) begin
      idle_cnt <= idle_cnt + 13'h1;
    end else begin
      // Silent too long: the mux falls back to the prescaler
      toggling <= 1'b0;
    end
  end

  // Synthesised slow clock: the prescaler holds each half period for
  // prescale+1 cycles and synth_clk is the fixed divide-by-2 flop,
  // so the period is 2*(prescale+1), from 2 to 512 cycles
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt <= 8'h0;
      synth_clk <= 1'b0;
      pre_run <= 1'b1;
    end else if (src == SRC_OSC || !good_main_clk) begin
      // Parked low so a restart begins with a full phase
      pre_cnt <= 8'h0;
      synth_clk <= 1'b0;
      pre_run <= 1'b0;
    end else begin
      pre_run <= 1'b1;
      if (pre_cnt >= prescale) begin
        pre_cnt <= 8'h0;
        synth_clk <= ~synth_clk;
      end else begin
        pre_cnt <= pre_cnt + 8'h1;
      end
    end
  end

  // Source changes only while both the current and new source are low,
  // so no shortened high phase reaches slow_clk
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      src <= SRC_PRESCALED;
    end else begin
      unique case (src)
        SRC_PRESCALED: begin
          if (sel_osc_req && toggling && !synth_clk && !slow_osc_in) begin
            src <= SRC_OSC;
          end
        end
        SRC_OSC: begin
          // A dead crystal forces the way back even while software asks
          if ((!sel_osc_req || !toggling) && !slow_osc_in) begin
            src <= SRC_PRESCALED;
          end
        end
      endcase
    end
  end

  // Registered output: one cycle of lag, but no glitch reaches the pin
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      slow_clk <= 1'b0;
    end else begin
      slow_clk <= mux_level;
    end
  end

  // Power-on reset counter runs only on a stable main clock
  // The pin only gates the output, so the count finishes while it is low
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      por_cnt <= `POR_PRESET;
      sys_rst_n <= 1'b0;
    end else begin
      if (por_cnt != 14'h0 && good_main_clk) begin
        por_cnt <= por_cnt - 14'h1;
      end
      sys_rst_n <= (por_cnt == 14'h0) & ext_reset_n;
    end
  end

  // Control register write
  // Byte strobes let the divisor change without touching the select
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sel_osc_req <= 1'b0;
      prescale <= `CTRL_PRE_RST;
    end else if (wr_go && is_ctrl(axil_req.awaddr)) begin
      if (axil_req.wstrb[0]) begin
        sel_osc_req <= axil_req.wdata[`CTRL_SEL_BIT];
      end
      if (axil_req.wstrb[1]) begin
        prescale <= axil_req.wdata[`CTRL_PRE_LSB +: 8];
      end
    end
  end

  // Write channel: both ready pulse together once address and data wait
  // No new ready is offered while a response still waits to be taken
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      axil_rsp.awready <= 1'b0;
      axil_rsp.wready <= 1'b0;
      axil_rsp.bvalid <= 1'b0;
      axil_rsp.bresp <= `RESP_OKAY;
    end else begin
      axil_rsp.awready <= 1'b0;
      axil_rsp.wready <= 1'b0;
      if (wr_go) begin
        axil_rsp.bvalid <= 1'b1;
        axil_rsp.bresp <= (is_ctrl(axil_req.awaddr) || is_status(axil_req.awaddr))
          ? `RESP_OKAY : `RESP_SLVERR;
      end else if (axil_rsp.bvalid && axil_req.bready) begin
        axil_rsp.bvalid <= 1'b0;
      // Both readies together, so address and data go in one edge
      end else if (!axil_rsp.bvalid && !axil_rsp.awready
                   && axil_req.awvalid && axil_req.wvalid) begin
        axil_rsp.awready <= 1'b1;
        axil_rsp.wready <= 1'b1;
      end
    end
  end

  // Read channel
  // Unmapped reads answer zero with an error response
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      axil_rsp.arready <= 1'b0;
      axil_rsp.rvalid <= 1'b0;
      axil_rsp.rdata <= 32'h0;
      axil_rsp.rresp <= `RESP_OKAY;
    end else begin
      axil_rsp.arready <= 1'b0;
      if (rd_go) begin
        axil_rsp.rvalid <= 1'b1;
        axil_rsp.rresp <= `RESP_OKAY;
        axil_rsp.rdata <= 32'h0;
        if (is_ctrl(axil_req.araddr)) begin
          axil_rsp.rdata[`CTRL_SEL_BIT] <= sel_osc_req;
          axil_rsp.rdata[`CTRL_PRE_LSB +: 8] <= prescale;
        end else if (is_status(axil_req.araddr)) begin
          // Timers are read live, mid-count
          axil_rsp.rdata[`ST_GOOD_MAIN] <= good_main_clk;
          axil_rsp.rdata[`ST_GOOD_SLOW] <= good_slow_clk;
          axil_rsp.rdata[`ST_TOGGLING] <= toggling;
          axil_rsp.rdata[`ST_SRC_OSC] <= (src == SRC_OSC);
          axil_rsp.rdata[`ST_FAST_EN] <= fast_oscillator_clock_en;
          axil_rsp.rdata[`ST_PRE_RUN] <= pre_run;
          axil_rsp.rdata[`ST_SLOW_TMR_LSB +: 6] <= slow_tmr;
          axil_rsp.rdata[`ST_MAIN_TMR_LSB +: 14] <= main_tmr;
        end else begin
          axil_rsp.rresp <= `RESP_SLVERR;
        end
      end else if (axil_rsp.rvalid && axil_req.rready) begin
        axil_rsp.rvalid <= 1'b0;
      end else if (!axil_rsp.rvalid && !axil_rsp.arready && axil_req.arvalid) begin
        axil_rsp.arready <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/osc_ctrl_map.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef OSC_CTRL_MAP_SVH
`define OSC_CTRL_MAP_SVH
`define OFF_CTRL 4'h0
`define OFF_STATUS 4'h4
`define CTRL_SEL_BIT 0
`define CTRL_PRE_LSB 8
`define CTRL_PRE_RST 8'hff
`define ST_GOOD_MAIN 0
`define ST_GOOD_SLOW 1
`define ST_TOGGLING 2
`define ST_SRC_OSC 3
`define ST_FAST_EN 4
`define ST_PRE_RUN 5
`define ST_SLOW_TMR_LSB 8
`define ST_MAIN_TMR_LSB 16
`define MAIN_TMR_PRESET 14'h3fff
`define SLOW_TMR_PRESET 6'h3f
`define POR_PRESET 14'h3fff
`define SYS_CLK_HZ 40000000
`define MAIN_START_CYC 32768
`define MAIN_TICK_CYC (`MAIN_START_CYC / 16384)
`define TOGGLE_TIMEOUT_CYC 13'h1000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- core/osc_ctrl_pkg.sv ----
// Types shared by the oscillator start-up and slow clock select block
package osc_ctrl_pkg;
  typedef struct packed {
    logic awvalid;
    logic [3:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [3:0] araddr;
    logic rready;
  } axil_req_t;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;
  typedef enum logic [1:0] {
    SRC_PRESCALED = 2'b01,
    SRC_OSC = 2'b10
  } slow_src_t;
endpackage

// ---- testbench/osc_clock_control_checker.sv ----
// Port-level checks for the oscillator control block
`timescale 1ns/1ps
`default_nettype none
module osc_clock_control_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic stop_main_osc,
  input wire logic stop_slow_osc,
  input wire logic ext_reset_n,
  input wire logic fast_oscillator_clock_en,
  input wire logic slow_osc_en,
  input wire logic good_main_clk,
  input wire logic good_slow_clk,
  input wire logic sys_rst_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [16:0] run;
  // Saturates so a long run never wraps into the allowed window
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) run <= '0;
    else if (!fast_oscillator_clock_en) run <= '0;
    else if (!run[16]) run <= run + 17'h1;
  end
  sequence s_main_off;
    stop_main_osc ##1 !stop_main_osc;
  endsequence
  property p_main_hold;
    stop_main_osc |=> !fast_oscillator_clock_en && !good_main_clk;
  endproperty
  property p_main_run;
    $fell(stop_main_osc) |=> fast_oscillator_clock_en;
  endproperty
  property p_main_keep;
    good_main_clk && !stop_main_osc |=> good_main_clk;
  endproperty
  property p_main_delay;
    $rose(good_main_clk) |-> run inside {[17'd32764:17'd32772]};
  endproperty
  property p_main_wait;
    s_main_off |-> !good_main_clk [*8];
  endproperty
  property p_slow_hold;
    stop_slow_osc |=> !slow_osc_en && !good_slow_clk;
  endproperty
  property p_slow_up;
    $rose(good_slow_clk) |-> $past(slow_osc_en, 126);
  endproperty
  property p_rst_up;
    $rose(sys_rst_n) |-> ext_reset_n && $past(good_main_clk, 200);
  endproperty
  a_main_hold: assert property (p_main_hold)
    else $error("main oscillator runs under stop");
  a_main_run: assert property (p_main_run)
    else $error("main oscillator not restarted");
  a_main_keep: assert property (p_main_keep)
    else $error("good main clock dropped");
  a_main_delay: assert property (p_main_delay)
    else $error("good main clock at wrong time");
  a_main_wait: assert property (p_main_wait)
    else $error("good main clock too early");
  a_slow_hold: assert property (p_slow_hold)
    else $error("slow oscillator runs under stop");
  a_slow_up: assert property (p_slow_up)
    else $error("good slow clock too early");
  a_rst_up: assert property (p_rst_up)
    else $error("internal reset released early");
endmodule
bind osc_clock_control osc_clock_control_checker u_osc_clock_control_checker (
  .sys_clk(sys_clk), .rstn(rstn), .stop_main_osc(stop_main_osc),
  .stop_slow_osc(stop_slow_osc), .ext_reset_n(ext_reset_n),
  .fast_oscillator_clock_en(fast_oscillator_clock_en), .slow_osc_en(slow_osc_en),
  .good_main_clk(good_main_clk), .good_slow_clk(good_slow_clk), .sys_rst_n(sys_rst_n));
`default_nettype wire

// ---- testbench/pm_osc_model.sv ----
// Power management stand-in plus the slow crystal
`timescale 1ns/1ps
`default_nettype none
module pm_osc_model #(parameter int HALF = 20) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic want_main_off,
  input wire logic want_slow_off,
  input wire logic xtal_dead,
  input wire logic slow_osc_en,
  output logic stop_main_osc,
  output logic stop_slow_osc,
  output logic slow_osc_in
);
  int ph;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stop_main_osc <= 1'b0;
      stop_slow_osc <= 1'b0;
    end else begin
      stop_main_osc <= want_main_off;
      stop_slow_osc <= want_slow_off;
    end
  end
  // A disabled or dead crystal stays flat, never a stale toggle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) ph <= 0;
    else if (!slow_osc_en || xtal_dead) ph <= 0;
    else ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
  end
  assign slow_osc_in = (ph >= HALF);
endmodule
`default_nettype wire

// ---- testbench/test_dual_osc_startup_slow_clock_select.sv ----
// Self-checking bench for oscillator start-up and slow clock select
`timescale 1ns/1ps
`default_nettype none
`include "osc_ctrl_map.svh"
module test_dual_osc_startup_slow_clock_select;
  import osc_ctrl_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic ext_reset_n = 1'b0;
  logic want_main_off = 1'b0, want_slow_off = 1'b0, xtal_dead = 1'b0;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic stop_main, stop_slow, osc_in, fast_en, slow_en, good_main, good_slow;
  logic slow_clk, sys_rst_n;
  logic [31:0] rd;
  int mismatches = 0, compares = 0, n, m, p;
  wire [2:0] flags = {sys_rst_n, good_slow, good_main};
  always #12.5 sys_clk = ~sys_clk;
  osc_clock_control u_osc_clock_control (.sys_clk(sys_clk), .rstn(rstn), .axil_req(req),
    .axil_rsp(rsp), .stop_main_osc(stop_main), .stop_slow_osc(stop_slow),
    .slow_osc_in(osc_in), .ext_reset_n(ext_reset_n), .fast_oscillator_clock_en(fast_en),
    .slow_osc_en(slow_en), .good_main_clk(good_main), .good_slow_clk(good_slow),
    .slow_clk(slow_clk), .sys_rst_n(sys_rst_n));
  pm_osc_model u_pm_osc_model (.sys_clk(sys_clk), .rstn(rstn), .want_main_off(want_main_off),
    .want_slow_off(want_slow_off), .xtal_dead(xtal_dead), .slow_osc_en(slow_en),
    .stop_main_osc(stop_main), .stop_slow_osc(stop_slow), .slow_osc_in(osc_in));
  function automatic int div_of(input int pre);
    return 2 * (pre + 1);
  endfunction
  task automatic final_report;
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic step(input logic go, input int lim);
    @(posedge sys_clk);
    n++;
    if (n >= lim) begin
      mismatches++;
      $display("BAD %0t wait ran out", $time);
      final_report();
    end
  endtask
  task automatic wait_for(input int f, input int lim);
    n = 0;
    do step(1'b1, lim); while (flags[f] !== 1'b1);
  endtask
  task automatic lvl(input logic v);
    while (slow_clk !== v) step(1'b1, 3000);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    n = 0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do step(1'b1, 50); while (rsp.awready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid <= 1'b0;
    do step(1'b1, 50); while (rsp.bvalid !== 1'b1);
    req.bready <= 1'b0;
    check(32'(rsp.bresp), 32'(er));
  endtask
  task automatic rdw(input logic [3:0] a, input logic [1:0] er);
    n = 0;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do step(1'b1, 50); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do step(1'b1, 50); while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    rd = rsp.rdata;
    check(32'(rsp.rresp), 32'(er));
  endtask
  task automatic period;
    n = 0;
    lvl(1'b0);
    lvl(1'b1);
    m = n;
    lvl(1'b0);
    lvl(1'b1);
    m = n - m;
  endtask
  initial begin
    void'($urandom(32'h8fb84f7a));
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    rdw(`OFF_CTRL, `RESP_OKAY);
    check(rd, 32'h0000ff00);
    wr(4'h8, 32'h1, `RESP_SLVERR);
    rdw(4'hc, `RESP_SLVERR);
    check(rd, 32'h0);
    wait_for(0, 33000);
    repeat (16400) @(posedge sys_clk);
    check(32'(sys_rst_n), 32'h0);
    ext_reset_n <= 1'b1;
    wait_for(2, 20);
    wait_for(1, 4000);
    // Prescale kept at 199 or more so the slow clock stays at or under 100 kHz
    for (int i = 0; i < 4; i++) begin
      p = (i == 0) ? 199 : (i == 1) ? 255 : 199 + $urandom_range(56);
      wr(`OFF_CTRL, 32'(p) << 8, `RESP_OKAY);
      period();
      check(32'(m), 32'(div_of(p)));
    end
    wr(`OFF_CTRL, 32'h0000c701, `RESP_OKAY);
    // The switch waits for both sources low, up to a synthesised period
    repeat (600) @(posedge sys_clk);
    rdw(`OFF_STATUS, `RESP_OKAY);
    // Prescaler parked, fast oscillator still on, oscillator is source
    check(32'(rd[5:3]), 32'h3);
    period();
    check(32'(m), 32'd40);
    xtal_dead <= 1'b1;
    repeat (4200) @(posedge sys_clk);
    rdw(`OFF_STATUS, `RESP_OKAY);
    check(32'(rd[3]), 32'h0);
    want_slow_off <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdw(`OFF_STATUS, `RESP_OKAY);
    check({good_slow, slow_en, 24'h0, rd[13:8]}, 32'h3f);
    want_main_off <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rdw(`OFF_STATUS, `RESP_OKAY);
    check({good_main, fast_en, 16'h0, rd[29:16]}, 32'h3fff);
    want_main_off <= 1'b0;
    wait_for(0, 33000);
    final_report();
  end
endmodule
`default_nettype wire
